// >>> verif/host_model.sv
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  output var  logic [9:0] addr_o,
  output var  logic       wr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       rd_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Register port cycles
  // ----------------------------------------------------------------
  initial begin
    addr_o = 10'h000;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // Released lines show the inverse so a stale value cannot pass
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #2;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #2;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #2;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  // ----------------------------------------------------------------
  // Tuning load; varactor and bias values assume one oscillator range
  // ----------------------------------------------------------------
  task automatic tune_pll();
    wr(10'h1B0, 8'h00);
    wr(10'h1B5, 8'h83);
    wr(10'h1B9, 8'h24);
    wr(10'h1BB, 8'h0C);
    wr(10'h1BC, 8'h0D);
    wr(10'h1BE, 8'h02);
    wr(10'h1BF, 8'h8E);
    wr(10'h1C0, 8'h2A);
    wr(10'h1C1, 8'h2A);
    wr(10'h1C4, 8'h7E);
    wr(10'h1C5, 8'h08);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import conv_regs_pkg::*;
  logic       clk;
  logic       rst;
  logic [9:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] rdata;
  logic       pat_bit;
  logic       pat_valid;
  logic [7:0] pq [11];
  logic [7:0] lane_pd;
  logic       bias_pd;
  int         failures = 0;
  int         checks = 0;
  logic [31:0] seed = 32'h2667;
  bit         hist[$];
  bit         tx[$];
  int         cnt = 0;
  bit         flag = 0;
  logic [2:0] ctl = 3'b000;
  logic [7:0] d;
  logic [9:0] ra [16] = '{10'h14B, 10'h14C, 10'h1B0, 10'h1B5, 10'h1B9, 10'h1BB, 10'h1BC,
    10'h1BE, 10'h1BF, 10'h1C0, 10'h1C1, 10'h1C4, 10'h1C5, 10'h200, 10'h201, 10'h150};
  logic [7:0] rv [16] = '{8'h00, 8'h00, 8'hFA, 8'h83, 8'h34, 8'h0C, 8'h00, 8'h00, 8'h8D,
    8'h2E, 8'h24, 8'h33, 8'h08, 8'h00, 8'h00, 8'h00};
  logic [7:0] rm [16] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h00};
  logic [7:0] rt [11] = '{8'h00, 8'h83, 8'h24, 8'h0C, 8'h0D, 8'h02, 8'h8E, 8'h2A, 8'h2A,
    8'h7E, 8'h08};
  host_model host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .rdata_i(rdata));
  conv_ctrl_regs dut (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .pat_bit_i(pat_bit),
    .pat_valid_i(pat_valid), .pll_power_o(pq[0]), .pll_var_tune_o(pq[1]),
    .pll_pump_a_o(pq[2]), .pll_bias_o(pq[3]), .pll_osc_ctl_o(pq[4]), .pll_osc_pwr_o(pq[5]),
    .pll_osc_cal_o(pq[6]), .pll_lock_o(pq[7]), .pll_pump_b_o(pq[8]), .pll_var_a_o(pq[9]),
    .pll_var_b_o(pq[10]), .lane_pd_o(lane_pd), .bias_pd_o(bias_pd));
  // ----------------------------------------------------------------
  // Helpers and reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Enable edge or mode change restarts seeding, so history is dropped
  task automatic set_ctl(input logic [7:0] v);
    host.wr(OFF_CHK_CTRL, v);
    if (!v[0] || !ctl[0] || v[2] != ctl[2]) begin
      hist.delete();
      flag = 0;
    end
    if (v[1]) cnt = 0;
    ctl = v[2:0];
  endtask
  task automatic stream(input int n, input int thr);
    int len;
    bit b;
    for (int i = 0; i < n; i++) begin
      len = ctl[2] ? 15 : 7;
      seed = lfsr(seed);
      b = (tx.size() >= len) ? tx[tx.size()-len] ^ tx[tx.size()-len+1] : seed[0];
      if (int'(seed[15:8]) < thr) b = ~b;
      tx.push_back(b);
      if (ctl[0]) begin
        if (hist.size() >= len) begin
          flag = (hist[hist.size()-len] ^ hist[hist.size()-len+1]) == b;
          if (!flag && !ctl[1] && cnt < 255) cnt++;
        end
        hist.push_back(b);
      end
      @(posedge clk);
      #2;
      pat_bit = b;
      pat_valid = 1'b1;
      @(posedge clk);
      #2;
      pat_valid = 1'b0;
      pat_bit = ~b;
    end
  endtask
  task automatic check_status();
    repeat (2) @(posedge clk);
    host.rd(OFF_CHK_CTRL, d);
    check("status", {1'b0, flag, 3'b000, ctl}, d);
    host.rd(OFF_ERR_COUNT, d);
    check("count", cnt[7:0], d);
  endtask
  task automatic check_pd(input logic [7:0] lanes, input logic bias);
    @(posedge clk);
    #2;
    check("lane_pd", lanes, lane_pd);
    check("bias_pd", {7'h00, bias}, {7'h00, bias_pd});
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    failures++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    pat_bit = 1'b0;
    pat_valid = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      host.rd(ra[i], d);
      check("reset value", rv[i], d);
    end
    check_pd(8'h00, 1'b0);
    $display("test reset values done");
    // Random data through every byte except the check control; read-only and unmapped places stay zero
    for (int i = 1; i < 16; i++) begin
      seed = lfsr(seed);
      host.wr(ra[i], seed[7:0]);
      host.rd(ra[i], d);
      check("readback", seed[7:0] & rm[i], d);
    end
    $display("test register access done");
    host.wr(OFF_RECEIVER_MASTER_POWERDOWN, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host.wr(OFF_LANE_PD, 8'h01 << i);
      check_pd(8'h01 << i, 1'b0);
    end
    host.wr(OFF_RECEIVER_MASTER_POWERDOWN, 8'hFF);
    check_pd(8'hFF, 1'b1);
    host.wr(OFF_RECEIVER_MASTER_POWERDOWN, 8'h00);
    check_pd(8'h80, 1'b0);
    $display("test power down done");
    host.tune_pll();
    for (int i = 0; i < 11; i++) begin
      host.rd(ra[i+2], d);
      check("tuned", rt[i], d);
      check("pll out", rt[i], pq[i]);
    end
    $display("test pll tuning done");
    for (int m = 0; m < 2; m++) begin
      set_ctl({5'b00000, m[0], 2'b01});
      stream(40, 0);
      check_status();
      stream(40, 40);
      check_status();
      set_ctl({5'b00000, m[0], 2'b00});
      stream(30, 80);
      check_status();
    end
    set_ctl(8'h03);
    stream(40, 80);
    check_status();
    set_ctl(8'h01);
    stream(30, 60);
    check_status();
    stream(600, 128);
    check_status();
    $display("test pattern checker done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verilog/conv_ctrl_regs.sv
`default_nettype none
// Functional notes
// - Match flag bit 6 reads 1 while pattern matches, 0 after a mismatch.
// - Polynomial select 0 checks the seven-stage x^7+x^6+1 sequence.
// - Polynomial select 1 checks the fifteen-stage x^15+x^14+1 sequence.
// - Master power-down bit 0 powers down all eight lanes and shared bias.
// - Lane power-down bit x powers down lane x only.
module conv_ctrl_regs
  import conv_regs_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [conv_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic [7:0]                    reg_wdata_i,
  input  wire logic                          reg_rd_i,
  output logic      [7:0]                    reg_rdata_o,
  input  wire logic                          pat_bit_i,
  input  wire logic                          pat_valid_i,
  output logic      [7:0]                    pll_power_o,
  output logic      [7:0]                    pll_var_tune_o,
  output logic      [7:0]                    pll_pump_a_o,
  output logic      [7:0]                    pll_bias_o,
  output logic      [7:0]                    pll_osc_ctl_o,
  output logic      [7:0]                    pll_osc_pwr_o,
  output logic      [7:0]                    pll_osc_cal_o,
  output logic      [7:0]                    pll_lock_o,
  output logic      [7:0]                    pll_pump_b_o,
  output logic      [7:0]                    pll_var_a_o,
  output logic      [7:0]                    pll_var_b_o,
  output logic      [conv_regs_pkg::LANES-1:0] lane_pd_o,
  output logic                               bias_pd_o
);
  import conv_regs_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0]       chk_ctl_r,   chk_ctl_nxt;
  logic [7:0]       pwr_r,       pwr_nxt;
  logic [7:0]       vtune_r,     vtune_nxt;
  logic [7:0]       pumpa_r,     pumpa_nxt;
  logic [7:0]       bias_r,      bias_nxt;
  logic [7:0]       octl_r,      octl_nxt;
  logic [7:0]       opwr_r,      opwr_nxt;
  logic [7:0]       ocal_r,      ocal_nxt;
  logic [7:0]       lock_r,      lock_nxt;
  logic [7:0]       pumpb_r,     pumpb_nxt;
  logic [7:0]       vara_r,      vara_nxt;
  logic [7:0]       varb_r,      varb_nxt;
  logic             allpd_r,     allpd_nxt;
  logic [LANES-1:0] lmask_r,     lmask_nxt;
  logic [7:0]       rdata_r,     rdata_nxt;
  logic [LANES-1:0] lane_pd_r,   lane_pd_nxt;
  logic             bias_pd_r,   bias_pd_nxt;
  logic             match_flag;
  logic [7:0]       err_count;

  // ----------------------------------------------------------------
  // Pattern checker
  // ----------------------------------------------------------------
  pattern_checker u_checker (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .enable_i   (chk_ctl_r[BIT_CHK_ENABLE]),
    .poly_sel_i (chk_ctl_r[BIT_POLY_SEL]),
    .clear_i    (chk_ctl_r[BIT_CNT_CLEAR]),
    .bit_i      (pat_bit_i),
    .valid_i    (pat_valid_i),
    .match_o    (match_flag),
    .count_o    (err_count)
  );

  // ----------------------------------------------------------------
  // Write decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    chk_ctl_nxt = chk_ctl_r;
    pwr_nxt     = pwr_r;
    vtune_nxt   = vtune_r;
    pumpa_nxt   = pumpa_r;
    bias_nxt    = bias_r;
    octl_nxt    = octl_r;
    opwr_nxt    = opwr_r;
    ocal_nxt    = ocal_r;
    lock_nxt    = lock_r;
    pumpb_nxt   = pumpb_r;
    vara_nxt    = vara_r;
    varb_nxt    = varb_r;
    allpd_nxt   = allpd_r;
    lmask_nxt   = lmask_r;
    rdata_nxt   = rdata_r;
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_CHK_CTRL) begin
        chk_ctl_nxt = reg_wdata_i[2:0];
      end else if (reg_addr_i == OFF_PLL_POWER) begin
        pwr_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_VAR_TUNE) begin
        vtune_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_PUMP_A) begin
        pumpa_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_BIAS) begin
        bias_nxt = reg_wdata_i & BIAS_FIELD_MASK;
      end else if (reg_addr_i == OFF_PLL_OSC_CTL) begin
        octl_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_OSC_PWR) begin
        opwr_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_OSC_CAL) begin
        ocal_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_LOCK) begin
        lock_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_PUMP_B) begin
        pumpb_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_VAR_A) begin
        vara_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_PLL_VAR_B) begin
        varb_nxt = reg_wdata_i;
      end else if (reg_addr_i == OFF_RECEIVER_MASTER_POWERDOWN) begin
        allpd_nxt = reg_wdata_i[BIT_ALL_PD];
      end else if (reg_addr_i == OFF_LANE_PD) begin
        lmask_nxt = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == OFF_CHK_CTRL) begin
        rdata_nxt = {1'b0, match_flag, 3'b000, chk_ctl_r};
      end else if (reg_addr_i == OFF_ERR_COUNT) begin
        rdata_nxt = err_count;
      end else if (reg_addr_i == OFF_PLL_POWER) begin
        rdata_nxt = pwr_r;
      end else if (reg_addr_i == OFF_PLL_VAR_TUNE) begin
        rdata_nxt = vtune_r;
      end else if (reg_addr_i == OFF_PLL_PUMP_A) begin
        rdata_nxt = pumpa_r;
      end else if (reg_addr_i == OFF_PLL_BIAS) begin
        rdata_nxt = bias_r;
      end else if (reg_addr_i == OFF_PLL_OSC_CTL) begin
        rdata_nxt = octl_r;
      end else if (reg_addr_i == OFF_PLL_OSC_PWR) begin
        rdata_nxt = opwr_r;
      end else if (reg_addr_i == OFF_PLL_OSC_CAL) begin
        rdata_nxt = ocal_r;
      end else if (reg_addr_i == OFF_PLL_LOCK) begin
        rdata_nxt = lock_r;
      end else if (reg_addr_i == OFF_PLL_PUMP_B) begin
        rdata_nxt = pumpb_r;
      end else if (reg_addr_i == OFF_PLL_VAR_A) begin
        rdata_nxt = vara_r;
      end else if (reg_addr_i == OFF_PLL_VAR_B) begin
        rdata_nxt = varb_r;
      end else if (reg_addr_i == OFF_RECEIVER_MASTER_POWERDOWN) begin
        rdata_nxt = {7'h00, allpd_r};
      end else if (reg_addr_i == OFF_LANE_PD) begin
        rdata_nxt = lmask_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    // Master bit overrides every lane so no lane runs without its bias
    lane_pd_nxt = lmask_nxt | {LANES{allpd_nxt}};
    bias_pd_nxt = allpd_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_ctl_r <= 3'b000;
      pwr_r     <= RST_PLL_POWER;
      vtune_r   <= RST_PLL_VAR_TUNE;
      pumpa_r   <= RST_PLL_PUMP_A;
      bias_r    <= RST_PLL_BIAS;
      octl_r    <= RST_PLL_OSC_CTL;
      opwr_r    <= RST_PLL_OSC_PWR;
      ocal_r    <= RST_PLL_OSC_CAL;
      lock_r    <= RST_PLL_LOCK;
      pumpb_r   <= RST_PLL_PUMP_B;
      vara_r    <= RST_PLL_VAR_A;
      varb_r    <= RST_PLL_VAR_B;
      allpd_r   <= 1'b0;
      lmask_r   <= 8'h00;
      rdata_r   <= 8'h00;
      lane_pd_r <= 8'h00;
      bias_pd_r <= 1'b0;
    end else begin
      chk_ctl_r <= chk_ctl_nxt;
      pwr_r     <= pwr_nxt;
      vtune_r   <= vtune_nxt;
      pumpa_r   <= pumpa_nxt;
      bias_r    <= bias_nxt;
      octl_r    <= octl_nxt;
      opwr_r    <= opwr_nxt;
      ocal_r    <= ocal_nxt;
      lock_r    <= lock_nxt;
      pumpb_r   <= pumpb_nxt;
      vara_r    <= vara_nxt;
      varb_r    <= varb_nxt;
      allpd_r   <= allpd_nxt;
      lmask_r   <= lmask_nxt;
      rdata_r   <= rdata_nxt;
      lane_pd_r <= lane_pd_nxt;
      bias_pd_r <= bias_pd_nxt;
    end
  end

  assign reg_rdata_o    = rdata_r;
  assign pll_power_o    = pwr_r;
  assign pll_var_tune_o = vtune_r;
  assign pll_pump_a_o   = pumpa_r;
  assign pll_bias_o     = bias_r;
  assign pll_osc_ctl_o  = octl_r;
  assign pll_osc_pwr_o  = opwr_r;
  assign pll_osc_cal_o  = ocal_r;
  assign pll_lock_o     = lock_r;
  assign pll_pump_b_o   = pumpb_r;
  assign pll_var_a_o    = vara_r;
  assign pll_var_b_o    = varb_r;
  assign lane_pd_o      = lane_pd_r;
  assign bias_pd_o      = bias_pd_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  master_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == OFF_RECEIVER_MASTER_POWERDOWN && reg_wdata_i[0]
    |=> lane_pd_o == 8'hFF && bias_pd_o)
    else $error("master power-down missed a lane or bias");
  lane_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == OFF_LANE_PD && !allpd_r
    |=> lane_pd_o == $past(reg_wdata_i))
    else $error("lane power-down not per lane");
  match_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == OFF_CHK_CTRL |=> reg_rdata_o[6] == $past(match_flag))
    else $error("match flag read wrong");
  count_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == OFF_ERR_COUNT |=> reg_rdata_o == $past(err_count))
    else $error("error count read wrong");
  cover_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == OFF_ERR_COUNT && err_count != 8'h00);
  cover_pd_c: cover property (@(posedge clk_i) disable iff (rst_i) bias_pd_o);
  cover_long_c: cover property (@(posedge clk_i) disable iff (rst_i)
    chk_ctl_r == 3'b101 && match_flag);
endmodule
`default_nettype wire

// >>> verilog/conv_regs_pkg.sv
`default_nettype none
package conv_regs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  OFF_CHK_CTRL    = 10'h14B;
  localparam logic [9:0]  OFF_ERR_COUNT   = 10'h14C;
  localparam logic [9:0]  OFF_PLL_POWER   = 10'h1B0;
  localparam logic [9:0]  OFF_PLL_VAR_TUNE = 10'h1B5;
  localparam logic [9:0]  OFF_PLL_PUMP_A  = 10'h1B9;
  localparam logic [9:0]  OFF_PLL_BIAS    = 10'h1BB;
  localparam logic [9:0]  OFF_PLL_OSC_CTL = 10'h1BC;
  localparam logic [9:0]  OFF_PLL_OSC_PWR = 10'h1BE;
  localparam logic [9:0]  OFF_PLL_OSC_CAL = 10'h1BF;
  localparam logic [9:0]  OFF_PLL_LOCK    = 10'h1C0;
  localparam logic [9:0]  OFF_PLL_PUMP_B  = 10'h1C1;
  localparam logic [9:0]  OFF_PLL_VAR_A   = 10'h1C4;
  localparam logic [9:0]  OFF_PLL_VAR_B   = 10'h1C5;
  localparam logic [9:0]  OFF_RECEIVER_MASTER_POWERDOWN   = 10'h200;
  localparam logic [9:0]  OFF_LANE_PD     = 10'h201;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          BIT_MATCH       = 6;
  localparam int          BIT_POLY_SEL    = 2;
  localparam int          BIT_CNT_CLEAR   = 1;
  localparam int          BIT_CHK_ENABLE  = 0;
  localparam int          BIT_ALL_PD      = 0;
  localparam logic [7:0]  BIAS_FIELD_MASK = 8'h1F;
  localparam int          LANES           = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_PLL_POWER   = 8'hFA;
  localparam logic [7:0]  RST_PLL_VAR_TUNE = 8'h83;
  localparam logic [7:0]  RST_PLL_PUMP_A  = 8'h34;
  localparam logic [7:0]  RST_PLL_BIAS    = 8'h0C;
  localparam logic [7:0]  RST_PLL_OSC_CTL = 8'h00;
  localparam logic [7:0]  RST_PLL_OSC_PWR = 8'h00;
  localparam logic [7:0]  RST_PLL_OSC_CAL = 8'h8D;
  localparam logic [7:0]  RST_PLL_LOCK    = 8'h2E;
  localparam logic [7:0]  RST_PLL_PUMP_B  = 8'h24;
  localparam logic [7:0]  RST_PLL_VAR_A   = 8'h33;
  localparam logic [7:0]  RST_PLL_VAR_B   = 8'h08;
  // ----------------------------------------------------------------
  // Checker sequence lengths and taps
  // ----------------------------------------------------------------
  localparam int          SHORT_LEN       = 7;
  localparam int          LONG_LEN        = 15;
  localparam logic [3:0]  FILL_SHORT      = 4'h7;
  localparam logic [3:0]  FILL_LONG       = 4'hF;
  localparam logic [7:0]  COUNT_MAX       = 8'hFF;
endpackage
`default_nettype wire

// >>> verilog/pattern_checker.sv
`default_nettype none
module pattern_checker
  import conv_regs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic       poly_sel_i,
  input  wire logic       clear_i,
  input  wire logic       bit_i,
  input  wire logic       valid_i,
  output logic            match_o,
  output logic [7:0]      count_o
);
  import conv_regs_pkg::*;

  // ----------------------------------------------------------------
  // Self-synchronising comparator
  // ----------------------------------------------------------------
  logic [14:0] hist_r,  hist_nxt;
  logic [3:0]  fill_r,  fill_nxt;
  logic        mode_r,  mode_nxt;
  logic        match_r, match_nxt;
  logic [7:0]  cnt_r,   cnt_nxt;
  logic        expect_bit;
  logic        miss;
  logic        armed;

  always_comb begin
    hist_nxt   = hist_r;
    fill_nxt   = fill_r;
    mode_nxt   = poly_sel_i;
    match_nxt  = match_r;
    cnt_nxt    = cnt_r;
    expect_bit = poly_sel_i ? (hist_r[LONG_LEN-1] ^ hist_r[LONG_LEN-2])
                            : (hist_r[SHORT_LEN-1] ^ hist_r[SHORT_LEN-2]);
    armed      = fill_r == (poly_sel_i ? FILL_LONG : FILL_SHORT);
    miss       = enable_i && valid_i && armed && (bit_i != expect_bit);
    // History must refill after a mode change, else a stale seed counts errors
    if (!enable_i || mode_r != poly_sel_i) begin
      fill_nxt  = 4'h0;
      match_nxt = 1'b0;
    end else if (valid_i) begin
      hist_nxt = {hist_r[13:0], bit_i};
      if (!armed) begin
        fill_nxt = fill_r + 4'h1;
      end else begin
        match_nxt = !miss;
      end
    end
    if (clear_i) begin
      cnt_nxt = 8'h00;
    end else if (miss && cnt_r != COUNT_MAX) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_r  <= 15'h0000;
      fill_r  <= 4'h0;
      mode_r  <= 1'b0;
      match_r <= 1'b0;
      cnt_r   <= 8'h00;
    end else begin
      hist_r  <= hist_nxt;
      fill_r  <= fill_nxt;
      mode_r  <= mode_nxt;
      match_r <= match_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign match_o = match_r;
  assign count_o = cnt_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  disabled_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i && !clear_i |=> cnt_r == $past(cnt_r))
    else $error("count moved while checker disabled");
  clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> cnt_r == 8'h00)
    else $error("count not zero under clear");
  miss_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    miss |=> !match_r)
    else $error("match flag high after mismatch");
  miss_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    miss && !clear_i && cnt_r != COUNT_MAX |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("mismatch not counted");
  short_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_i && valid_i && armed && !poly_sel_i && mode_r == poly_sel_i
    && bit_i == (hist_r[6] ^ hist_r[5]) |=> match_r)
    else $error("short sequence bit not accepted");
  long_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_i && valid_i && armed && poly_sel_i && mode_r == poly_sel_i
    && bit_i == (hist_r[14] ^ hist_r[13]) |=> match_r)
    else $error("long sequence bit not accepted");
  cover_lock_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !match_r ##1 match_r [*8]);
  cover_miss_c: cover property (@(posedge clk_i) disable iff (rst_i) match_r ##1 miss);
endmodule
`default_nettype wire
